// [verilog/clock_config_serial_register_bank.v]
/*
  Serially programmed configuration store of a single-loop clock generator:
  two-wire slave port, eight scratchpad blocks, a retained configuration
  bank, an active configuration bank, and the pin driven output enable and
  low power controls.
  Assumes the two-wire bus resolves sda and scl as open drain outside, the
  bus master keeps the protocol, and clk_i runs much faster than scl.
*/
//
// Overview of operation
// - Enable pin high drives divider outputs, low disables
// - Low-power pin low shuts down all clocks
// - Scratchpad blocks read zero until programmed
// - Default: oscillator runs, only first output driven
// - Default: write-lock pin and output-enable pin
// - Answer as ten separate slave devices
// - Retained bank answers default address 69H
// - Active bank answers default address 68H
// - Active bank writes apply immediately
// - Retained bank loads into active after reset
// - Eight-bit register address sent before data
// - Standard two-wire signalling, standard and fast
// - All slave addresses are reprogrammable
// - First divider: top bit source, seven-bit value
// - Second divider: top bit source, seven-bit value
// - Six three-bit selects packed, unused bits high
// - Load capacitor setting, bit 7 most significant
// - Oscillator drive fields, low three bits zero
// - Feedback lsb bit 7, reference divider 6:0
// - Write lock rejects scratchpad and retained writes
`include "clock_config_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module clock_config_serial_register_bank #(
  parameter SCRATCH_BLOCKS = 8, // Number of scratchpad blocks
  parameter [2:0] SRC_REF = 3'h1 // Crosspoint code that passes the reference
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Two-wire serial port
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  // Multi-function pins
  input wire oe_pin_i,
  input wire lock_pin_i,
  // Clock output controls
  output reg [5:0] clk_drive_o,
  output reg low_power_o,
  output reg osc_run_o,
  // Divider and crosspoint configuration
  output reg first_divider_source_o,
  output reg [6:0] first_linear_divider_o,
  output reg second_divider_source_o,
  output reg [6:0] second_linear_divider_o,
  output reg [17:0] output_source_select_o,
  // Oscillator and loop configuration
  output reg [7:0] crystal_load_setting_o,
  output reg [1:0] crystal_drive_gain_o,
  output reg load_cap_source_o,
  output reg [1:0] tuning_table_source_o,
  output reg [9:0] feedback_counter_o,
  output reg feedback_count_lsb_o,
  output reg [6:0] ref_divider_o,
  output reg [2:0] pump_o
);

  // ========================================================================
  // State codes, one-hot
  localparam [7:0] S_BOOT = 8'h01; // Copy retained bank to active bank
  localparam [7:0] S_IDLE = 8'h02; // Wait for start condition
  localparam [7:0] S_DEV = 8'h04; // Shift in slave address byte
  localparam [7:0] S_REG = 8'h08; // Shift in register address byte
  localparam [7:0] S_WR = 8'h10; // Shift in data bytes
  localparam [7:0] S_ACK = 8'h20; // Acknowledge clock
  localparam [7:0] S_RD = 8'h40; // Shift out data byte
  localparam [7:0] S_RACK = 8'h80; // Sample master acknowledge

  // ========================================================================
  // Storage
  reg [7:0] scratch [0:SCRATCH_BLOCKS*256-1]; // Scratchpad blocks
  reg [7:0] nv [0:255]; // Retained configuration bank
  reg [7:0] act [0:255]; // Active configuration bank
  integer k; // Init loop index

  // Factory contents: blank scratchpad and default configuration
  initial begin
    for (k = 0; k < SCRATCH_BLOCKS*256; k = k + 1) begin
      scratch[k] = 8'h00;
    end
    for (k = 0; k < 256; k = k + 1) begin
      nv[k] = 8'h00;
      act[k] = 8'h00;
    end
    nv[`OFS_OE_MASK] = `DEF_OE_MASK;
    nv[`OFS_DIV1] = `DEF_DIV;
    nv[`OFS_PIN_CTRL] = `DEF_PIN_CTRL;
    nv[`OFS_LOCK_CTRL] = `DEF_LOCK_CTRL;
    nv[`OFS_OSC_DRIVE] = `DEF_OSC_DRIVE;
    nv[`OFS_LOAD_CAP] = `DEF_LOAD_CAP;
    nv[`OFS_PUMP_FB_HI] = `HIGH_PUMP;
    nv[`OFS_XSEL_A] = {SRC_REF, 5'h00};
    nv[`OFS_XSEL_B] = `HIGH_XSEL_B;
    nv[`OFS_XSEL_C] = `HIGH_XSEL_C;
    nv[`OFS_DIV2] = `DEF_DIV;
    nv[`OFS_SCRATCH_BASE] = `DEF_SCRATCH_BASE;
    nv[`OFS_NV_ADDR] = `DEF_NV_ADDR;
    nv[`OFS_ACT_ADDR] = `DEF_ACT_ADDR;
  end

  // ========================================================================
  // Fixed bit handling, applied to both configuration banks
  function [7:0] fix_bits;
    input [7:0] a; // Register address
    input [7:0] d; // Written data
    begin
      case (a)
        `OFS_OE_MASK: fix_bits = d & `KEEP_OE_MASK;
        `OFS_LOCK_CTRL: fix_bits = d & `KEEP_LOCK_CTRL;
        `OFS_OSC_DRIVE: fix_bits = d & `KEEP_OSC_DRIVE;
        `OFS_TUNE_ADC: fix_bits = d & `KEEP_TUNE_ADC;
        `OFS_PUMP_FB_HI: fix_bits = (d & `KEEP_PUMP) | `HIGH_PUMP;
        `OFS_XSEL_B: fix_bits = d | `HIGH_XSEL_B;
        `OFS_XSEL_C: fix_bits = d | `HIGH_XSEL_C;
        default: fix_bits = d;
      endcase
    end
  endfunction

  // ========================================================================
  // Pin synchronisers, two flops each
  reg [1:0] scl_sync; // Serial clock
  reg [1:0] sda_sync; // Serial data
  reg [1:0] oe_sync; // Output enable / low power pin
  reg [1:0] lock_sync; // Write lock pin
  reg scl_d; // Previous synchronised clock
  reg sda_d; // Previous synchronised data

  // Bring pins into the clock domain
  always @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      oe_sync <= 2'h0;
      lock_sync <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      oe_sync <= {oe_sync[0], oe_pin_i};
      lock_sync <= {lock_sync[0], lock_pin_i};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  // Bus events, all from second synchroniser stage
  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_ev = scl_s & scl_d & ~sda_d & sda_s;

  // ========================================================================
  // Slave address decode
  reg [6:0] scratch_base; // Scratchpad address base, low three bits ignored
  reg [6:0] nv_addr; // Retained bank slave address
  reg [6:0] act_addr; // Active bank slave address
  reg write_lock; // Combined write lock
  reg [7:0] state; // Serial state
  reg [7:0] ack_next; // State after the acknowledge clock
  reg [3:0] bitcnt; // Bits shifted in the current byte
  reg [7:0] shreg; // Shift register
  reg [3:0] sel; // Selected block: 0..7 scratch, 8 retained, 9 active
  reg [7:0] ptr; // Register address pointer
  reg [8:0] boot_idx; // Boot copy index

  // Ten slave identities, active bank first
  wire hit_act = (shreg[7:1] == act_addr);
  wire hit_nv = (shreg[7:1] == nv_addr);
  wire hit_scr = (shreg[7:4] == scratch_base[6:3]);
  wire dev_hit = hit_act | hit_nv | hit_scr;
  wire [3:0] dev_sel = hit_act ? 4'h9 : (hit_nv ? 4'h8 : {1'b0, shreg[3:1]});

  // Read data of the selected block
  wire [10:0] scr_idx = {sel[2:0], ptr};
  wire [7:0] rd_byte = (sel == 4'h9) ? act[ptr] :
                       ((sel == 4'h8) ? nv[ptr] : scratch[scr_idx]);
  // Nonvolatile targets are the scratchpad and the retained bank
  wire wr_refused = write_lock & (sel != 4'h9);

  // ========================================================================
  // Serial slave state machine and bank writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_BOOT;
      ack_next <= S_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      sel <= 4'h0;
      ptr <= 8'h00;
      boot_idx <= 9'h000;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (state == S_BOOT) begin
      // Load active bank from retained bank, bus ignored meanwhile
      act[boot_idx[7:0]] <= nv[boot_idx[7:0]];
      boot_idx <= boot_idx + 9'h001;
      if (boot_idx == `BOOT_LAST) begin
        state <= S_IDLE;
      end
    end else if (start_ev) begin
      // Start or repeated start: expect slave address
      state <= S_DEV;
      bitcnt <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (stop_ev) begin
      // Stop: release bus
      state <= S_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      case (state)
        S_DEV, S_REG, S_WR: begin
          // Shift in on rising clock, act on falling after eighth bit
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            bitcnt <= 4'h0;
            if (state == S_DEV) begin
              // Seven-bit address, direction in lsb
              if (dev_hit) begin
                sel <= dev_sel;
                sda_oe_o <= 1'b1;
                state <= S_ACK;
                ack_next <= shreg[0] ? S_RD : S_REG;
              end else begin
                state <= S_IDLE;
              end
            end else if (state == S_REG) begin
              // Register address comes before data
              ptr <= shreg;
              sda_oe_o <= 1'b1;
              state <= S_ACK;
              ack_next <= S_WR;
            end else if (wr_refused) begin
              // Locked write: no acknowledge, byte dropped
              state <= S_IDLE;
            end else begin
              // Store the byte and advance the pointer
              if (sel == 4'h9) begin
                act[ptr] <= fix_bits(ptr, shreg);
              end else if (sel == 4'h8) begin
                nv[ptr] <= fix_bits(ptr, shreg);
              end else begin
                scratch[scr_idx] <= shreg;
              end
              ptr <= ptr + 8'h01;
              sda_oe_o <= 1'b1;
              state <= S_ACK;
              ack_next <= S_WR;
            end
          end
        end
        S_ACK: begin
          // End of acknowledge clock: release or start a read byte
          if (scl_fall) begin
            if (ack_next == S_RD) begin
              shreg <= rd_byte;
              sda_oe_o <= ~rd_byte[7];
              ptr <= ptr + 8'h01;
              bitcnt <= 4'h1;
            end else begin
              sda_oe_o <= 1'b0;
              bitcnt <= 4'h0;
            end
            state <= ack_next;
          end
        end
        S_RD: begin
          // Shift out on falling clock, msb first
          if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              sda_oe_o <= 1'b0;
              state <= S_RACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_oe_o <= ~shreg[6];
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          // Master acknowledge continues the read, no acknowledge ends it
          if (scl_rise) begin
            if (sda_s) begin
              state <= S_IDLE;
            end else begin
              state <= S_ACK;
              ack_next <= S_RD;
            end
          end
        end
        S_IDLE: begin
          // Wait for a start condition
          sda_oe_o <= 1'b0;
        end
        default: begin
          state <= S_IDLE;
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // Active configuration decode, refreshed every cycle
  wire [7:0] oe_mask = act[`OFS_OE_MASK];
  wire [7:0] pin_ctrl = act[`OFS_PIN_CTRL];
  wire [7:0] lock_ctrl = act[`OFS_LOCK_CTRL];
  wire [7:0] div1 = act[`OFS_DIV1];
  wire [7:0] div2 = act[`OFS_DIV2];
  wire [7:0] osc_drv = act[`OFS_OSC_DRIVE];
  wire [7:0] pump_hi = act[`OFS_PUMP_FB_HI];
  wire [7:0] ref_div = act[`OFS_REF_DIV];
  wire [7:0] xsel_b = act[`OFS_XSEL_B];
  wire [7:0] xsel_c = act[`OFS_XSEL_C];
  wire low_power_mode = pin_ctrl[`BIT_LOW_POWER_EN]; // Pin works as low power
  wire next_low_power = low_power_mode & ~oe_sync[1];
  wire pin_gate = low_power_mode | oe_sync[1];
  wire [5:0] mask6 = {oe_mask[6], oe_mask[5], oe_mask[3:0]};

  // Drive configuration outputs from the active bank
  always @(posedge clk_i) begin
    if (rst_i) begin
      scratch_base <= 7'h00;
      nv_addr <= 7'h00;
      act_addr <= 7'h00;
      write_lock <= 1'b0;
      clk_drive_o <= 6'h00;
      low_power_o <= 1'b0;
      osc_run_o <= 1'b0;
      first_divider_source_o <= 1'b0;
      first_linear_divider_o <= 7'h00;
      second_divider_source_o <= 1'b0;
      second_linear_divider_o <= 7'h00;
      output_source_select_o <= 18'h00000;
      crystal_load_setting_o <= 8'h00;
      crystal_drive_gain_o <= 2'h0;
      load_cap_source_o <= 1'b0;
      tuning_table_source_o <= 2'h0;
      feedback_counter_o <= 10'h000;
      feedback_count_lsb_o <= 1'b0;
      ref_divider_o <= 7'h00;
      pump_o <= 3'h0;
    end else begin
      // Slave addresses held in the active bank
      scratch_base <= act[`OFS_SCRATCH_BASE][6:0];
      nv_addr <= act[`OFS_NV_ADDR][6:0];
      act_addr <= act[`OFS_ACT_ADDR][6:0];
      // Pin lock when routed, plus memory lock bit
      write_lock <= (lock_ctrl[`BIT_LOCK_SRC] & lock_sync[1]) |
                    lock_ctrl[`BIT_MEM_LOCK];
      // Output drive: mask, pin gate and low power
      clk_drive_o <= (next_low_power | ~pin_gate) ? 6'h00 : mask6;
      low_power_o <= next_low_power;
      osc_run_o <= ~next_low_power;
      first_divider_source_o <= div1[7];
      first_linear_divider_o <= div1[6:0];
      second_divider_source_o <= div2[7];
      second_linear_divider_o <= div2[6:0];
      // First output in the top three bits, sixth in the lowest
      output_source_select_o <= {act[`OFS_XSEL_A], xsel_b[7:4], xsel_b[0],
                                 xsel_c[7:3]};
      crystal_load_setting_o <= act[`OFS_LOAD_CAP];
      tuning_table_source_o <= osc_drv[7:6];
      load_cap_source_o <= osc_drv[5];
      crystal_drive_gain_o <= osc_drv[4:3];
      pump_o <= pump_hi[4:2];
      feedback_counter_o <= {pump_hi[1:0], act[`OFS_FB_LO]};
      feedback_count_lsb_o <= ref_div[7];
      ref_divider_o <= ref_div[6:0];
    end
  end

endmodule

`default_nettype wire

// [inc/clock_config_defs.vh]
/*
  Constants of the clock configuration register bank: register offsets,
  fixed bit masks, factory defaults and serial slave addresses.
  Assumes it is included by its bare name from the design files.
*/
`ifndef CLOCK_CONFIG_DEFS_VH
`define CLOCK_CONFIG_DEFS_VH

// ==========================================================================
// Register offsets (eight-bit register addresses)
`define OFS_OE_MASK 8'h09
`define OFS_DIV1 8'h0C
`define OFS_PIN_CTRL 8'h10
`define OFS_LOCK_CTRL 8'h11
`define OFS_OSC_DRIVE 8'h12
`define OFS_LOAD_CAP 8'h13
`define OFS_TUNE_ADC 8'h14
`define OFS_PUMP_FB_HI 8'h40
`define OFS_FB_LO 8'h41
`define OFS_REF_DIV 8'h42
`define OFS_XSEL_A 8'h44
`define OFS_XSEL_B 8'h45
`define OFS_XSEL_C 8'h46
`define OFS_DIV2 8'h47
`define OFS_SCRATCH_BASE 8'hF0
`define OFS_NV_ADDR 8'hF1
`define OFS_ACT_ADDR 8'hF2

// ==========================================================================
// Field positions
`define BIT_LOW_POWER_EN 2
`define BIT_LOCK_SRC 3
`define BIT_MEM_LOCK 4

// ==========================================================================
// Fixed bit handling: keep masks and forced-high patterns
`define KEEP_OE_MASK 8'h6F
`define KEEP_LOCK_CTRL 8'h1F
`define KEEP_OSC_DRIVE 8'hF8
`define KEEP_TUNE_ADC 8'hFE
`define KEEP_PUMP 8'h1F
`define HIGH_PUMP 8'hC0
`define HIGH_XSEL_B 8'h0E
`define HIGH_XSEL_C 8'h07

// ==========================================================================
// Factory default configuration
`define DEF_OE_MASK 8'h01
`define DEF_DIV 8'h08
`define DEF_PIN_CTRL 8'h00
`define DEF_LOCK_CTRL 8'h08
`define DEF_OSC_DRIVE 8'h20
`define DEF_LOAD_CAP 8'h80
`define DEF_XSEL_A 8'h20
`define DEF_SCRATCH_BASE 8'h50
`define DEF_NV_ADDR 8'h69
`define DEF_ACT_ADDR 8'h68

// ==========================================================================
// Boot copy last index (bytes per configuration bank minus one)
`define BOOT_LAST 9'h0FF

`endif

// [verification/clock_config_chk.sv]
/*
  Checker for the clock configuration register bank: pin controls,
  serial data line discipline and configuration stability.
  Assumes it is bound to the bank's top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module clock_config_chk #(
  parameter [2:0] SRC_REF = 3'h1 // Crosspoint code of the reference
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial lines and pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic oe_pin_i,
  // Configuration outputs
  input wire logic [5:0] clk_drive_o,
  input wire logic low_power_o,
  input wire logic osc_run_o,
  input wire logic [17:0] output_source_select_o,
  input wire logic [7:0] crystal_load_setting_o,
  input wire logic [6:0] ref_divider_o,
  input wire logic [9:0] feedback_counter_o
);
  // ====
  // Idle bus counter, saturating
  logic [8:0] quiet;

  // Counts cycles with both lines high since either line was last low
  always @(posedge clk_i) begin
    if (rst_i || !(scl_i && sda_i)) begin
      quiet <= 9'h000;
    end else if (quiet != 9'h1FF) begin
      quiet <= quiet + 9'h001;
    end
  end

  // ====
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  pin_off_dark_a: assert property ($fell(oe_pin_i) |->
    ##[1:6] (clk_drive_o == 6'h00 || low_power_o)) else $error("outputs stay on");
  pin_high_awake_a: assert property (oe_pin_i [*6] |-> !low_power_o)
    else $error("low power with pin high");
  sleep_dark_a: assert property (low_power_o |-> clk_drive_o == 6'h00)
    else $error("outputs driven in low power");
  boot_default_a: assert property ($fell(rst_i) |-> ##270
    (osc_run_o && output_source_select_o[17:15] == SRC_REF)) else $error("bad boot state");
  sda_drain_a: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven high");
  sda_moves_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line moved with clock high");
  ack_holds_a: assert property ($rose(scl_i) && sda_oe_o |=> sda_oe_o [*4])
    else $error("driven bit dropped early");
  idle_stable_a: assert property (quiet > 9'h12C |-> $stable({crystal_load_setting_o,
    ref_divider_o, feedback_counter_o, output_source_select_o})) else $error("config drift");

  // Main scenarios reached
  cover property ($rose(sda_oe_o));
  cover property ($rose(low_power_o));
  cover property ($fell(oe_pin_i) ##6 clk_drive_o == 6'h00);
endmodule

bind clock_config_serial_register_bank clock_config_chk #(.SRC_REF(SRC_REF)) u_clock_config_chk (
  .clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .oe_pin_i, .clk_drive_o,
  .low_power_o, .osc_run_o, .output_source_select_o, .crystal_load_setting_o,
  .ref_divider_o, .feedback_counter_o
);

`default_nettype wire

// [verification/serial_master_model.sv]
/*
  Two-wire bus master model: start, stop, byte transfers and register
  write and read transactions. Assumes a pull-up on the data line and
  that the caller resolves the line from all drivers.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_master_model (
  // Clock
  input wire logic clk_i,
  // Bus lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // Bus starts idle and released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Quarter of a bit, slow against the system clock
  task quarter;
    repeat (6) @(negedge clk_i);
  endtask

  // Start or repeated start: data falls with clock high
  task start_cond;
    begin
      sda_low_o = 1'b0;
      quarter;
      scl_o = 1'b1;
      quarter;
      sda_low_o = 1'b1;
      quarter;
      scl_o = 0;
      quarter;
    end
  endtask

  // Stop: data rises with clock high
  task stop_cond;
    begin
      sda_low_o = 1'b1;
      quarter;
      scl_o = 1'b1;
      quarter;
      sda_low_o = 1'b0;
      quarter;
    end
  endtask

  // One bit: data set with clock low, sampled mid high
  task bit_xfer(input b, output s);
    begin
      sda_low_o = !b;
      quarter;
      scl_o = 1'b1;
      quarter;
      s = sda_i;
      quarter;
      scl_o = 1'b0;
      quarter;
    end
  endtask

  // Byte out, msb first, then the answer bit
  task byte_out(input [7:0] b, output ack);
    integer j;
    reg s;
    begin
      for (j = 7; j >= 0; j = j - 1) begin
        bit_xfer(b[j], s);
      end
      bit_xfer(1'b1, s);
      ack = !s;
    end
  endtask

  // Byte in, msb first, ended by a refusal bit
  task byte_in(output [7:0] b);
    integer j;
    reg s;
    begin
      b = 8'h00;
      for (j = 0; j < 8; j = j + 1) begin
        bit_xfer(1'b1, s);
        b = {b[6:0], s};
      end
      bit_xfer(1'b1, s);
    end
  endtask

  // Register write: address, register, data
  task write_reg(input [6:0] dev, input [7:0] ra, input [7:0] d, output [2:0] acks);
    reg a2, a1, a0;
    begin
      start_cond;
      byte_out({dev, 1'b0}, a2);
      byte_out(ra, a1);
      byte_out(d, a0);
      stop_cond;
      acks = {a2, a1, a0};
    end
  endtask

  // Register read through a repeated start
  task read_reg(input [6:0] dev, input [7:0] ra, output [7:0] d, output [2:0] acks);
    reg a2, a1, a0;
    begin
      start_cond;
      byte_out({dev, 1'b0}, a2);
      byte_out(ra, a1);
      start_cond;
      byte_out({dev, 1'b1}, a0);
      byte_in(d);
      stop_cond;
      acks = {a2, a1, a0};
    end
  endtask
endmodule

`default_nettype wire

// [verification/clock_config_serial_register_bank_bench.sv]
/*
  Self-checking bench of the clock configuration register bank.
  Assumes the master model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    checks = checks + 1; \
    if ((g) !== (e)) begin \
      n_errors = n_errors + 1; \
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e); \
    end \
  end

module clock_config_serial_register_bank_bench;
  // ====
  // Stimulus and wiring
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg oe_pin_i = 1'b1;
  reg lock_pin_i = 1'b0;
  wire scl_i, sda_i, sda_o, sda_oe_o, sda_low, low_power_o, osc_run_o;
  wire first_divider_source_o, second_divider_source_o, load_cap_source_o;
  wire feedback_count_lsb_o;
  wire [5:0] clk_drive_o;
  wire [6:0] first_linear_divider_o, second_linear_divider_o, ref_divider_o;
  wire [17:0] output_source_select_o;
  wire [7:0] crystal_load_setting_o;
  wire [1:0] crystal_drive_gain_o, tuning_table_source_o;
  wire [9:0] feedback_counter_o;
  wire [2:0] pump_o;
  integer n_errors = 0;
  integer checks = 0;
  reg [3:0] i;
  reg [2:0] acks;
  reg [7:0] rd;
  // Offsets, written bytes and expected read back
  localparam [87:0] OFS = 88'h090C4713124244454640_41;
  localparam [87:0] WRV = 88'h6FA53C5AF893A45E2FDE_3C;
  localparam [87:0] RDV = 88'h6FA53C5AF893A45E2FDE_3C;

  // Clock of 50 ns
  always #25 clk_i = !clk_i;

  // Data line with pull-up, pulled low by either party
  assign sda_i = !(sda_low || (sda_oe_o && !sda_o));

  clock_config_serial_register_bank u_clock_config_serial_register_bank (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .oe_pin_i(oe_pin_i), .lock_pin_i(lock_pin_i),
    .clk_drive_o(clk_drive_o), .low_power_o(low_power_o), .osc_run_o(osc_run_o),
    .first_divider_source_o(first_divider_source_o),
    .first_linear_divider_o(first_linear_divider_o),
    .second_divider_source_o(second_divider_source_o),
    .second_linear_divider_o(second_linear_divider_o),
    .output_source_select_o(output_source_select_o),
    .crystal_load_setting_o(crystal_load_setting_o),
    .crystal_drive_gain_o(crystal_drive_gain_o), .load_cap_source_o(load_cap_source_o),
    .tuning_table_source_o(tuning_table_source_o), .feedback_counter_o(feedback_counter_o),
    .feedback_count_lsb_o(feedback_count_lsb_o), .ref_divider_o(ref_divider_o),
    .pump_o(pump_o)
  );

  serial_master_model u_serial_master_model (
    .clk_i(clk_i), .sda_i(sda_i), .scl_o(scl_i), .sda_low_o(sda_low)
  );

  // ====
  // Tasks
  task stop_test;
    begin
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask

  // Reset for 12 cycles, then wait out the boot copy
  task do_reset;
    begin
      rst_i = 1'b1;
      repeat (12) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (300) @(negedge clk_i);
    end
  endtask

  // Write and compare the three answer bits
  task write_check(input [6:0] dev, input [7:0] ra, input [7:0] d, input [2:0] ea);
    begin
      u_serial_master_model.write_reg(dev, ra, d, acks);
      `CHK(acks, ea)
    end
  endtask

  // Read and compare answers and data
  task read_check(input [6:0] dev, input [7:0] ra, input [7:0] ed);
    begin
      u_serial_master_model.read_reg(dev, ra, rd, acks);
      `CHK(acks, 3'h7)
      `CHK(rd, ed)
    end
  endtask

  // Pin change, then settle through the synchroniser
  task set_pin(input v);
    begin
      oe_pin_i = v;
      repeat (6) @(negedge clk_i);
    end
  endtask

  // ====
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk_i);
    n_errors = n_errors + 1;
    $display("watchdog expired");
    stop_test;
  end

  // ====
  // Test sequence
  initial begin
    do_reset;
    `CHK(osc_run_o, 1'b1)
    `CHK(clk_drive_o, 6'h01)
    `CHK(output_source_select_o[17:15], 3'h1)
    `CHK({load_cap_source_o, tuning_table_source_o}, 3'h4)
    set_pin(1'b0);
    `CHK(clk_drive_o, 6'h00)
    `CHK(low_power_o, 1'b0)
    set_pin(1'b1);
    `CHK(clk_drive_o, 6'h01)
    $display("defaults and enable pin done");
    for (i = 0; i < 11; i = i + 1) begin
      write_check(7'h68, OFS[87-8*i -: 8], WRV[87-8*i -: 8], 3'h7);
      read_check(7'h68, OFS[87-8*i -: 8], RDV[87-8*i -: 8]);
    end
    `CHK(clk_drive_o, 6'h3F)
    `CHK({first_divider_source_o, first_linear_divider_o}, 8'hA5)
    `CHK({second_divider_source_o, second_linear_divider_o}, 8'h3C)
    `CHK(crystal_load_setting_o, 8'h5A)
    `CHK({tuning_table_source_o, load_cap_source_o, crystal_drive_gain_o}, 5'h1F)
    `CHK({feedback_count_lsb_o, ref_divider_o}, 8'h93)
    `CHK(output_source_select_o, 18'h29145)
    `CHK({pump_o, feedback_counter_o}, 13'h1E3C)
    $display("active bank registers done");
    write_check(7'h68, 8'h10, 8'h04, 3'h7);
    set_pin(1'b0);
    `CHK({low_power_o, clk_drive_o}, 7'h40)
    set_pin(1'b1);
    `CHK(low_power_o, 1'b0)
    write_check(7'h68, 8'h10, 8'h00, 3'h7);
    $display("low power done");
    for (i = 0; i < 8; i = i + 1) begin
      read_check({4'hA, i[2:0]}, 8'h05, 8'h00);
      write_check({4'hA, i[2:0]}, 8'h05, {5'h18, i[2:0]}, 3'h7);
      read_check({4'hA, i[2:0]}, 8'h05, {5'h18, i[2:0]});
    end
    write_check(7'h6A, 8'h05, 8'h00, 3'h0);
    $display("scratch blocks done");
    write_check(7'h69, 8'h13, 8'h3C, 3'h7);
    read_check(7'h69, 8'h13, 8'h3C);
    `CHK(crystal_load_setting_o, 8'h5A)
    lock_pin_i = 1'b1;
    write_check(7'h69, 8'h13, 8'h77, 3'h6);
    read_check(7'h69, 8'h13, 8'h3C);
    write_check(7'h68, 8'h13, 8'h11, 3'h7);
    `CHK(crystal_load_setting_o, 8'h11)
    lock_pin_i = 1'b0;
    do_reset;
    `CHK(crystal_load_setting_o, 8'h3C)
    $display("retained bank and lock done");
    write_check(7'h68, 8'hF2, 8'h3A, 3'h7);
    read_check(7'h3A, 8'h13, 8'h3C);
    write_check(7'h68, 8'h13, 8'h00, 3'h0);
    $display("address change done");
    stop_test;
  end
endmodule

`default_nettype wire
